/* hdl/dump_pkg.sv */
// constants and types for the debug memory block dump command
`default_nettype none
package dump_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int SHIFT_W = 40;

   // command byte encoding: upper nibble, fixed bit 1, size in [3:2], with-status in bit 0
   localparam logic [3:0] OP_HIGH_NIBBLE = 4'h3;
   localparam int OP_FIXED_BIT = 1;
   localparam int OP_SIZE_LSB = 2;
   localparam int OP_WS_BIT = 0;

   localparam logic [7:0] OP_DUMP_B = 8'h32;
   localparam logic [7:0] OP_DUMP_W = 8'h36;
   localparam logic [7:0] OP_DUMP_L = 8'h3A;
   localparam logic [7:0] OP_DUMP_WS_B = 8'h33;
   localparam logic [7:0] OP_DUMP_WS_W = 8'h37;
   localparam logic [7:0] OP_DUMP_WS_L = 8'h3B;

   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [2:0] CNT_RESET = 3'h0;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } op_size_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MEMRD = 3'b001,
      ST_STAT = 3'b010,
      ST_ACK = 3'b011,
      ST_SEND = 3'b100
   } dump_state_t;

   // read request towards the memory arbiter
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      op_size_t size;
   } mem_req_t;

   // start of region, given by the preceding single read command
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      op_size_t size;
   } region_start_t;

endpackage : dump_pkg

`default_nettype wire

/* hdl/memory_block_dump.sv */
// block dump command engine of the background debug controller
`timescale 1ns/10ps
`default_nettype none

// Contract
// - The single read sets the region start and comes before any dump command, which is ignored until then.
// - Every dump command fetches the next operand, never the start location again.
// - After the single read the start address plus the operand size of 1, 2 or 4 is kept as the temporary address.
// - Each dump reads at the temporary address and then writes back that address plus the operand size.
// - The with-status variant sends the low debug status byte before the data bytes.
// - The status byte is sampled after the memory read of that command has completed.
// - With handshaking enabled an acknowledge pulse is driven before the data bytes are sent.
// - Command bytes 0x33, 0x37 and 0x3B select the with-status dump of byte, word and long operands.
module memory_block_dump (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // region start from the single read command
   input wire logic start_valid,
   input wire dump_pkg::region_start_t start_info,
   // command byte from the link layer
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   output logic cmd_ready,
   // handshake option and acknowledge pulse request
   input wire logic ack_enable,
   output logic ack_pulse,
   // memory read port
   output logic mem_req_valid,
   output dump_pkg::mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [dump_pkg::DATA_W-1:0] mem_rdata,
   // controller state
   input wire logic [7:0] debug_status_low_byte,
   // bytes towards the link layer, and the region-open flag
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   output logic region_open
);

   dump_pkg::dump_state_t state_ff, nxt_state;
   logic [dump_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
   dump_pkg::op_size_t size_ff, nxt_size;
   logic ws_ff, nxt_ws;
   logic open_ff, nxt_open;
   logic [dump_pkg::DATA_W-1:0] data_ff, nxt_data;
   logic [7:0] stat_ff, nxt_stat;
   logic [dump_pkg::SHIFT_W-1:0] sh_ff, nxt_sh;
   logic [2:0] cnt_ff, nxt_cnt;

   wire logic idle = (state_ff == dump_pkg::ST_IDLE);
   wire logic cmd_fire = cmd_valid && cmd_ready;
   wire logic tx_fire = tx_valid && tx_ready;

   wire logic op_is_dump = (cmd_byte[7:4] == dump_pkg::OP_HIGH_NIBBLE) && cmd_byte[dump_pkg::OP_FIXED_BIT]
      && (cmd_byte[dump_pkg::OP_SIZE_LSB +: 2] != 2'b11);
   wire dump_pkg::op_size_t op_size = dump_pkg::op_size_t'(cmd_byte[dump_pkg::OP_SIZE_LSB +: 2]);
   wire logic op_ws = cmd_byte[dump_pkg::OP_WS_BIT];

   function automatic logic [dump_pkg::ADDR_W-1:0] step_of(input dump_pkg::op_size_t sz);
      logic [dump_pkg::ADDR_W-1:0] s;
      s = 32'h0000_0001;
      if (sz == dump_pkg::SZ_WORD) begin
         s = 32'h0000_0002;
      end else if (sz == dump_pkg::SZ_LONG) begin
         s = 32'h0000_0004;
      end
      return s;
   endfunction : step_of

   // operand aligned to the top of a long word, msb first
   wire logic [dump_pkg::DATA_W-1:0] aligned =
      (size_ff == dump_pkg::SZ_BYTE) ? {mem_rdata[7:0], 24'h00_0000} :
      (size_ff == dump_pkg::SZ_WORD) ? {mem_rdata[15:0], 16'h0000} : mem_rdata;
   wire logic [2:0] nbytes = (size_ff == dump_pkg::SZ_BYTE) ? 3'h1 : (size_ff == dump_pkg::SZ_WORD) ? 3'h2 : 3'h4;
   wire logic [2:0] last_idx = nbytes + {2'b00, ws_ff} - 3'h1;

   // handshake and data outputs
   assign cmd_ready = idle && !start_valid;
   assign mem_req_valid = (state_ff == dump_pkg::ST_MEMRD);
   assign mem_req.addr = addr_ff;
   assign mem_req.size = size_ff;
   assign ack_pulse = (state_ff == dump_pkg::ST_ACK) && ack_enable;
   assign tx_valid = (state_ff == dump_pkg::ST_SEND);
   assign tx_byte = sh_ff[dump_pkg::SHIFT_W-1 -: 8];
   assign region_open = open_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_size = size_ff;
      nxt_ws = ws_ff;
      nxt_open = open_ff;
      nxt_data = data_ff;
      nxt_stat = stat_ff;
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         dump_pkg::ST_IDLE: begin
            if (start_valid) begin
               nxt_addr = start_info.addr + step_of(start_info.size);
               nxt_size = start_info.size;
               nxt_open = 1'b1;
            end else if (cmd_fire && op_is_dump && open_ff) begin
               nxt_size = op_size;
               nxt_ws = op_ws;
               nxt_state = dump_pkg::ST_MEMRD;
            end
         end
         dump_pkg::ST_MEMRD: begin
            if (mem_ack) begin
               nxt_data = aligned;
               nxt_addr = addr_ff + step_of(size_ff);
               nxt_state = dump_pkg::ST_STAT;
            end
         end
         dump_pkg::ST_STAT: begin
            nxt_stat = debug_status_low_byte;
            nxt_sh = ws_ff ? {debug_status_low_byte, data_ff} : {data_ff, dump_pkg::PAD_BYTE};
            nxt_cnt = dump_pkg::CNT_RESET;
            nxt_state = dump_pkg::ST_ACK;
         end
         dump_pkg::ST_ACK: begin
            nxt_state = dump_pkg::ST_SEND;
         end
         dump_pkg::ST_SEND: begin
            if (tx_fire) begin
               nxt_sh = {sh_ff[dump_pkg::SHIFT_W-9:0], dump_pkg::PAD_BYTE};
               nxt_cnt = cnt_ff + 3'h1;
               if (cnt_ff == last_idx) begin
                  nxt_state = dump_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            nxt_state = dump_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= dump_pkg::ST_IDLE;
         addr_ff <= dump_pkg::ADDR_RESET;
         size_ff <= dump_pkg::SZ_BYTE;
         ws_ff <= 1'b0;
         open_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         size_ff <= nxt_size;
         ws_ff <= nxt_ws;
         open_ff <= nxt_open;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         data_ff <= 32'h0000_0000;
         stat_ff <= 8'h00;
         sh_ff <= 40'h00_0000_0000;
         cnt_ff <= dump_pkg::CNT_RESET;
      end else begin
         data_ff <= nxt_data;
         stat_ff <= nxt_stat;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
      end
   end

   localparam logic [2:0] CNT_ZERO = dump_pkg::CNT_RESET;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   AST_START_ADDR: assert property (idle && start_valid |=> open_ff
         && addr_ff == $past(start_info.addr) + step_of($past(start_info.size)))
      else $error("temporary address not start plus size");

   AST_ADDR_STEP: assert property (mem_req_valid && mem_ack |=> addr_ff == $past(addr_ff) + step_of(size_ff)
         && state_ff == dump_pkg::ST_STAT)
      else $error("address did not advance by operand size");

   AST_NEXT_OPERAND: assert property (mem_req_valid && mem_ack |=> mem_req.addr != $past(mem_req.addr))
      else $error("dump re-read the same location");

   AST_NEED_START: assert property (cmd_fire && !open_ff |=> idle)
      else $error("dump accepted before region start");

   AST_DECODE_WS_L: assert property (cmd_fire && open_ff && cmd_byte == dump_pkg::OP_DUMP_WS_L |=> ws_ff
         && size_ff == dump_pkg::SZ_LONG && mem_req_valid)
      else $error("0x3B not decoded as long with status");

   AST_STATUS_AFTER: assert property (state_ff == dump_pkg::ST_STAT |=> stat_ff == $past(debug_status_low_byte)
         && state_ff == dump_pkg::ST_ACK)
      else $error("status not sampled after memory read");

   AST_STATUS_FIRST: assert property (tx_valid && ws_ff && cnt_ff == CNT_ZERO |-> tx_byte == stat_ff)
      else $error("first byte of with-status dump is not status");

   AST_ACK_FIRST: assert property (state_ff == dump_pkg::ST_ACK && ack_enable |-> ack_pulse
         ##1 (tx_valid && cnt_ff == CNT_ZERO))
      else $error("acknowledge not ahead of data");

   AST_MSB_FIRST: assert property (tx_valid && !ws_ff && cnt_ff == CNT_ZERO |-> tx_byte == data_ff[31:24])
      else $error("operand not sent msb first");

   COV_DUMP_LONG_WS: cover property (cmd_fire && open_ff && cmd_byte == dump_pkg::OP_DUMP_WS_L);
   COV_DUMP_BYTE: cover property (cmd_fire && open_ff && cmd_byte == dump_pkg::OP_DUMP_B);
   COV_BACK_PRESSURE: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
   COV_ACK_SENT: cover property (ack_pulse ##1 tx_valid);

endmodule : memory_block_dump

`default_nettype wire

/* verif/mem_model.sv */
// memory and controller-status partner for the block dump engine
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // memory read port
   input wire logic mem_req_valid,
   input wire dump_pkg::mem_req_t mem_req,
   output logic mem_ack,
   output logic [dump_pkg::DATA_W-1:0] mem_rdata,
   // controller state
   output logic [7:0] debug_status_low_byte
);
   logic [1:0] wait_ff;
   logic [7:0] acks_ff;
   logic [31:0] junk_ff;
   // answer after 0..3 cycles, set by the low address bits
   assign mem_ack = mem_req_valid && (wait_ff == mem_req.addr[1:0]);
   // data is the inverted address, noise while no answer
   assign mem_rdata = mem_ack ? ~mem_req.addr : junk_ff;
   assign debug_status_low_byte = acks_ff;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wait_ff <= 2'h0;
         acks_ff <= 8'h00;
         junk_ff <= 32'h5A5A_A5A5;
      end else begin
         wait_ff <= (mem_req_valid && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
         acks_ff <= acks_ff + {7'h00, mem_ack};
         junk_ff <= ~junk_ff;
      end
   end
endmodule : mem_model
`default_nettype wire

/* verif/test_memory_block_dump.sv */
// self-checking bench for the block dump engine
`timescale 1ns/10ps
`default_nettype none
module test_memory_block_dump;
   logic mclk = 1'b0, rstn = 1'b0, start_valid = 1'b0, cmd_valid = 1'b0, ack_enable = 1'b0, tx_ready = 1'b1;
   dump_pkg::region_start_t start_info = '0;
   logic [7:0] cmd_byte = 8'h00;
   wire logic cmd_ready, ack_pulse, mem_req_valid, mem_ack, tx_valid, region_open;
   wire dump_pkg::mem_req_t mem_req;
   wire logic [31:0] mem_rdata;
   wire logic [7:0] stat, tx_byte;
   int n_mismatch = 0, tests_run = 0, n_acks = 0;
   logic [31:0] next_addr = 32'h0;
   memory_block_dump dut (.mclk(mclk), .rstn(rstn), .start_valid(start_valid), .start_info(start_info),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .ack_enable(ack_enable),
      .ack_pulse(ack_pulse), .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .debug_status_low_byte(stat), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .region_open(region_open));
   mem_model mem (.mclk(mclk), .rstn(rstn), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .debug_status_low_byte(stat));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic give_verdict();
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic do_reset();
      @(negedge mclk) rstn = 1'b0;
      repeat (5) @(negedge mclk);
      rstn = 1'b1;
      n_acks = 0;
      chk("region_open", 0, region_open);
      chk("tx_valid", 0, tx_valid);
   endtask : do_reset
   task automatic send(input logic [7:0] op, input logic en);
      int i;
      @(negedge mclk);
      ack_enable = en;
      cmd_byte = op;
      cmd_valid = 1'b1;
      for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge mclk);
      if (cmd_ready !== 1'b1) begin
         n_mismatch++;
         give_verdict();
      end
      @(negedge mclk) cmd_valid = 1'b0;
   endtask : send
   task automatic start(input logic [31:0] a, input dump_pkg::op_size_t sz);
      @(negedge mclk);
      start_info.addr = a;
      start_info.size = sz;
      start_valid = 1'b1;
      @(negedge mclk) start_valid = 1'b0;
      next_addr = a + (32'h1 << sz);
      chk("region_open", 1, region_open);
   endtask : start
   task automatic drop(input logic [7:0] op);
      logic busy;
      busy = 1'b0;
      send(op, 1'b1);
      repeat (8) @(negedge mclk) busy = busy | mem_req_valid | tx_valid;
      chk("dropped command busy", 0, busy);
   endtask : drop
   task automatic dump(input logic [7:0] op, input logic en);
      logic [7:0] e[5];
      logic [31:0] d;
      logic seen, achk;
      int nb, ws, k, i;
      ws = op[0];
      nb = 1 << op[3:2];
      d = ~next_addr;
      e[0] = 8'(n_acks + 1);
      for (i = 0; i < nb; i++) e[ws + i] = d[8 * (nb - 1 - i) +: 8];
      seen = 1'b0;
      achk = 1'b0;
      k = 0;
      send(op, en);
      for (i = 0; i < 100 && k < nb + ws; i++) begin
         if (mem_req_valid === 1'b1 && !achk) begin
            chk("mem_req.addr", next_addr, mem_req.addr);
            chk("mem_req.size", op[3:2], mem_req.size);
            chk("cmd_ready busy", 0, cmd_ready);
         end
         achk = achk | mem_req_valid;
         if (ack_pulse === 1'b1 && k == 0) seen = 1'b1;
         if (tx_valid === 1'b1 && tx_ready) begin
            chk("tx_byte", e[k], tx_byte);
            k++;
         end
         if (k < nb + ws) @(negedge mclk) tx_ready = ~tx_ready;
      end
      tx_ready = 1'b1;
      if (k < nb + ws) begin
         n_mismatch++;
         give_verdict();
      end
      chk("ack before data", en, seen);
      next_addr = next_addr + nb;
      n_acks++;
   endtask : dump
   initial begin
      do_reset();
      drop(8'h33);
      start(32'h0000_1000, dump_pkg::SZ_LONG);
      dump(8'h3B, 1'b1);
      dump(8'h37, 1'b0);
      dump(8'h33, 1'b1);
      dump(8'h3A, 1'b0);
      dump(8'h36, 1'b1);
      dump(8'h32, 1'b0);
      drop(8'h10);
      dump(8'h37, 1'b1);
      start(32'h0000_2003, dump_pkg::SZ_BYTE);
      dump(8'h3B, 1'b1);
      do_reset();
      drop(8'h32);
      give_verdict();
   end
endmodule : test_memory_block_dump
`default_nettype wire
